// ==== logic/aai_alu.sv ====
// 8-bit adder with condition flags and 16-bit index adder
`timescale 1ns/1ps
module aai_alu (
	aai_alu_if.alu bus
);
	logic [7:0] a;
	logic [7:0] m;
	logic [7:0] r;

	assign a = bus.acc;
	assign m = bus.opnd;
	assign r = 8'(a + m + {7'h00, bus.carry_in});
	assign bus.sum = r;
	// carry out of bit 3, same form with or without carry in
	assign bus.half = (a[3] & m[3]) | (m[3] & ~r[3]) | (~r[3] & a[3]);
	assign bus.neg = r[7];
	assign bus.zero = (r == 8'h00);
	assign bus.ovf = (a[7] & m[7] & ~r[7]) | (~a[7] & ~m[7] & r[7]);
	assign bus.carry = (a[7] & m[7]) | (m[7] & ~r[7]) | (~r[7] & a[7]);
	// operand zero-extended, carry ripples into the high byte
	assign bus.idx_sum = bus.idx + {8'h00, m};

endmodule // aai_alu

// ==== logic/aai_alu_if.sv ====
// carrier between the sequencer and the adder
`timescale 1ns/1ps
interface aai_alu_if;
	logic [7:0] acc;
	logic [7:0] opnd;
	logic carry_in;
	logic [15:0] idx;
	logic [7:0] sum;
	logic half;
	logic neg;
	logic zero;
	logic ovf;
	logic carry;
	logic [15:0] idx_sum;
	modport core (output acc, opnd, carry_in, idx,
		input sum, half, neg, zero, ovf, carry, idx_sum);
	modport alu (input acc, opnd, carry_in, idx,
		output sum, half, neg, zero, ovf, carry, idx_sum);
endinterface

// ==== logic/aai_core.sv ====
// execution core for the accumulator and index add instructions
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module aai_core (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [7:0] i_mem_data,
	output logic [15:0] o_mem_addr,
	output logic o_mem_rw,
	output logic o_mem_cycle,
	input wire logic [7:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [7:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready
);
	aai_pkg::aai_state_e state_r, state_nxt;
	aai_pkg::aai_kind_e kind_r, kind_nxt;
	aai_pkg::aai_mode_e mode_r, mode_nxt;
	logic selb_r, selb_nxt;
	logic [7:0] hold_r, hold_nxt;
	logic [15:0] pc_r, pc_nxt;
	logic [15:0] addr_r, addr_nxt;
	logic [7:0] acc_a_r, acc_b_r, flags_r;
	logic [15:0] x_r, y_r;
	logic run_r, illegal_r, rw_r, cycle_r;
	logic execute, bad_op, arith;
	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [7:0] aw_addr_r;
	logic [31:0] wdata_r, rdata_r, rd_word;
	logic [3:0] wstrb_r;
	logic wr_go, wr_halted, rd_hit;
	aai_alu_if alu_bus ();

	aai_alu u_alu (
		.bus(alu_bus)
	);

	// ---------------------------------------------------------------
	// adder operand steering
	// ---------------------------------------------------------------
	always_comb begin
		arith = (kind_r == aai_pkg::K_CARRY) || (kind_r == aai_pkg::K_ACC_SUM);
		alu_bus.acc = selb_r ? acc_b_r : acc_a_r;
		alu_bus.carry_in = (kind_r == aai_pkg::K_CARRY) &&
			flags_r[aai_pkg::FLG_CARRY];
		if (kind_r != aai_pkg::K_CARRY) begin
			alu_bus.opnd = acc_b_r;
		end else if (state_r == aai_pkg::ST_DUMMY) begin
			alu_bus.opnd = hold_r;
		end else begin
			alu_bus.opnd = i_mem_data;
		end
		alu_bus.idx = (kind_r == aai_pkg::K_ADD_BY ||
			mode_r == aai_pkg::MODE_YIDX) ? y_r : x_r;
	end

	// ---------------------------------------------------------------
	// instruction sequencer
	// ---------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		kind_nxt = kind_r;
		mode_nxt = mode_r;
		selb_nxt = selb_r;
		hold_nxt = hold_r;
		pc_nxt = pc_r;
		addr_nxt = addr_r;
		execute = 1'b0;
		bad_op = 1'b0;
		unique case (state_r)
			aai_pkg::ST_IDLE: begin
				if (run_r) begin
					state_nxt = aai_pkg::ST_OP1;
					addr_nxt = pc_r;
				end
			end
			aai_pkg::ST_OP1: begin
				pc_nxt = pc_r + 16'h0001;
				addr_nxt = pc_nxt;
				state_nxt = aai_pkg::ST_OPND;
				kind_nxt = aai_pkg::K_CARRY;
				selb_nxt = i_mem_data[6];
				mode_nxt = aai_pkg::MODE_IMMED;
				unique case (i_mem_data)
					aai_pkg::OPC_Y_PREFIX: state_nxt = aai_pkg::ST_OP2;
					aai_pkg::OPC_ACC_SUM: begin
						kind_nxt = aai_pkg::K_ACC_SUM;
						selb_nxt = 1'b0;
						state_nxt = aai_pkg::ST_SKIP;
					end
					aai_pkg::OPC_ADD_B_X: begin
						kind_nxt = aai_pkg::K_ADD_BX;
						state_nxt = aai_pkg::ST_SKIP;
					end
					aai_pkg::OPC_CARRY_A_IMMED,
					aai_pkg::OPC_CARRY_B_IMMED: mode_nxt = aai_pkg::MODE_IMMED;
					aai_pkg::OPC_CARRY_A_DIRECT,
					aai_pkg::OPC_CARRY_B_DIRECT: mode_nxt = aai_pkg::MODE_DIRECT;
					aai_pkg::OPC_CARRY_A_EXTENDED,
					aai_pkg::OPC_CARRY_B_EXTENDED:
						mode_nxt = aai_pkg::MODE_EXTENDED;
					aai_pkg::OPC_CARRY_A_INDEXED,
					aai_pkg::OPC_CARRY_B_INDEXED: mode_nxt = aai_pkg::MODE_XIDX;
					default: bad_op = 1'b1;
				endcase
			end
			aai_pkg::ST_OP2: begin
				pc_nxt = pc_r + 16'h0001;
				addr_nxt = pc_nxt;
				state_nxt = aai_pkg::ST_OPND;
				kind_nxt = aai_pkg::K_CARRY;
				selb_nxt = i_mem_data[6];
				mode_nxt = aai_pkg::MODE_YIDX;
				unique case (i_mem_data)
					aai_pkg::OPC_ADD_B_X: begin
						kind_nxt = aai_pkg::K_ADD_BY;
						state_nxt = aai_pkg::ST_SKIP;
					end
					aai_pkg::OPC_CARRY_A_INDEXED,
					aai_pkg::OPC_CARRY_B_INDEXED: ;
					default: bad_op = 1'b1;
				endcase
			end
			aai_pkg::ST_SKIP: begin
				// data of this read is ignored; pc does not move
				if (kind_r == aai_pkg::K_ACC_SUM) begin
					execute = 1'b1;
				end else begin
					state_nxt = aai_pkg::ST_DUMMY;
					addr_nxt = aai_pkg::DUMMY_ADDR;
				end
			end
			aai_pkg::ST_OPND: begin
				pc_nxt = pc_r + 16'h0001;
				hold_nxt = i_mem_data;
				unique case (mode_r)
					aai_pkg::MODE_IMMED: execute = 1'b1;
					aai_pkg::MODE_DIRECT: begin
						state_nxt = aai_pkg::ST_MEM;
						addr_nxt = {aai_pkg::PAGE_ZERO, i_mem_data};
					end
					aai_pkg::MODE_EXTENDED: begin
						state_nxt = aai_pkg::ST_ADLO;
						addr_nxt = pc_nxt;
					end
					default: begin
						state_nxt = aai_pkg::ST_DUMMY;
						addr_nxt = aai_pkg::DUMMY_ADDR;
					end
				endcase
			end
			aai_pkg::ST_ADLO: begin
				pc_nxt = pc_r + 16'h0001;
				state_nxt = aai_pkg::ST_MEM;
				addr_nxt = {hold_r, i_mem_data};
			end
			aai_pkg::ST_DUMMY: begin
				if (kind_r != aai_pkg::K_CARRY) begin
					execute = 1'b1;
				end else begin
					state_nxt = aai_pkg::ST_MEM;
					addr_nxt = alu_bus.idx_sum;
				end
			end
			aai_pkg::ST_MEM: execute = 1'b1;
		endcase
		if (execute) begin
			state_nxt = run_r ? aai_pkg::ST_OP1 : aai_pkg::ST_IDLE;
			addr_nxt = pc_nxt;
		end
		if (bad_op) begin
			// halt with pc left on the faulting opcode
			state_nxt = aai_pkg::ST_IDLE;
			pc_nxt = pc_r;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_r <= aai_pkg::ST_IDLE;
			kind_r <= aai_pkg::K_ACC_SUM;
			mode_r <= aai_pkg::MODE_IMMED;
			selb_r <= 1'b0;
			hold_r <= 8'h00;
			addr_r <= aai_pkg::PC_RST;
			cycle_r <= 1'b0;
			rw_r <= 1'b1;
		end else if (i_ce) begin
			state_r <= state_nxt;
			kind_r <= kind_nxt;
			mode_r <= mode_nxt;
			selb_r <= selb_nxt;
			hold_r <= hold_nxt;
			addr_r <= addr_nxt;
			cycle_r <= (state_nxt != aai_pkg::ST_IDLE);
			rw_r <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// programmer-visible registers
	// ---------------------------------------------------------------
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// core registers only accept software writes while halted
	assign wr_halted = wr_go && (state_r == aai_pkg::ST_IDLE);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			acc_a_r <= 8'h00;
			acc_b_r <= 8'h00;
			x_r <= 16'h0000;
			y_r <= 16'h0000;
			flags_r <= aai_pkg::FLAGS_RST;
		end else if (i_ce) begin
			if (execute && arith) begin
				if (selb_r) begin
					acc_b_r <= alu_bus.sum;
				end else begin
					acc_a_r <= alu_bus.sum;
				end
				flags_r[aai_pkg::FLG_HALF] <= alu_bus.half;
				flags_r[aai_pkg::FLG_NEG] <= alu_bus.neg;
				flags_r[aai_pkg::FLG_ZERO] <= alu_bus.zero;
				flags_r[aai_pkg::FLG_OVF] <= alu_bus.ovf;
				flags_r[aai_pkg::FLG_CARRY] <= alu_bus.carry;
			end
			if (execute && kind_r == aai_pkg::K_ADD_BX) begin
				x_r <= alu_bus.idx_sum;
			end
			if (execute && kind_r == aai_pkg::K_ADD_BY) begin
				y_r <= alu_bus.idx_sum;
			end
			if (wr_halted) begin
				unique case (aw_addr_r)
					aai_pkg::REG_ACC_A: acc_a_r <= 8'(merge16(
						{8'h00, acc_a_r}, wdata_r, wstrb_r));
					aai_pkg::REG_ACC_B: acc_b_r <= 8'(merge16(
						{8'h00, acc_b_r}, wdata_r, wstrb_r));
					aai_pkg::REG_X_INDEX: x_r <= merge16(x_r, wdata_r, wstrb_r);
					aai_pkg::REG_Y_INDEX: y_r <= merge16(y_r, wdata_r, wstrb_r);
					aai_pkg::REG_FLAGS: flags_r <= 8'(merge16(
						{8'h00, flags_r}, wdata_r, wstrb_r));
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pc_r <= aai_pkg::PC_RST;
		end else if (i_ce) begin
			if (wr_halted && aw_addr_r == aai_pkg::REG_PC) begin
				pc_r <= merge16(pc_r, wdata_r, wstrb_r);
			end else begin
				pc_r <= pc_nxt;
			end
		end
	end

	// a bad opcode drops run so the core does not spin on it
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			run_r <= 1'b0;
			illegal_r <= 1'b0;
		end else if (i_ce) begin
			if (bad_op) begin
				run_r <= 1'b0;
			end else if (wr_go && aw_addr_r == aai_pkg::REG_CTRL &&
				wstrb_r[0]) begin
				run_r <= wdata_r[aai_pkg::CTRL_RUN];
			end
			// set wins over the write-one clear
			if (bad_op) begin
				illegal_r <= 1'b1;
			end else if (wr_go && aw_addr_r == aai_pkg::REG_STATUS &&
				wstrb_r[0] && wdata_r[aai_pkg::STAT_ILLEGAL]) begin
				illegal_r <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// axi4-lite slave
	// ---------------------------------------------------------------
	assign wr_go = !awready_r && !wready_r && !bvalid_r;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= aai_pkg::RESP_OKAY;
			aw_addr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else if (i_ce) begin
			if (awready_r && i_s_axi_awvalid) begin
				awready_r <= 1'b0;
				aw_addr_r <= i_s_axi_awaddr;
			end
			if (wready_r && i_s_axi_wvalid) begin
				wready_r <= 1'b0;
				wdata_r <= i_s_axi_wdata;
				wstrb_r <= i_s_axi_wstrb;
			end
			if (wr_go) begin
				bvalid_r <= 1'b1;
				bresp_r <= (aw_addr_r > aai_pkg::REG_FLAGS ||
					aw_addr_r[1:0] != 2'b00) ?
					aai_pkg::RESP_SLVERR : aai_pkg::RESP_OKAY;
			end else if (bvalid_r && i_s_axi_bready) begin
				bvalid_r <= 1'b0;
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
		end
	end

	always_comb begin
		rd_hit = 1'b1;
		unique case (i_s_axi_araddr)
			aai_pkg::REG_CTRL: rd_word = {31'h0, run_r};
			aai_pkg::REG_STATUS: rd_word = {30'h0, illegal_r,
				state_r == aai_pkg::ST_IDLE};
			aai_pkg::REG_ACC_A: rd_word = {24'h0, acc_a_r};
			aai_pkg::REG_ACC_B: rd_word = {24'h0, acc_b_r};
			aai_pkg::REG_X_INDEX: rd_word = {16'h0, x_r};
			aai_pkg::REG_Y_INDEX: rd_word = {16'h0, y_r};
			aai_pkg::REG_PC: rd_word = {16'h0, pc_r};
			aai_pkg::REG_FLAGS: rd_word = {24'h0, flags_r};
			default: begin
				rd_word = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= aai_pkg::RESP_OKAY;
		end else if (i_ce) begin
			if (arready_r && i_s_axi_arvalid) begin
				arready_r <= 1'b0;
				rvalid_r <= 1'b1;
				rdata_r <= rd_word;
				rresp_r <= rd_hit ? aai_pkg::RESP_OKAY : aai_pkg::RESP_SLVERR;
			end else if (rvalid_r && i_s_axi_rready) begin
				rvalid_r <= 1'b0;
				arready_r <= 1'b1;
			end
		end
	end

	assign o_mem_addr = addr_r;
	assign o_mem_rw = rw_r;
	assign o_mem_cycle = cycle_r;
	assign o_s_axi_awready = awready_r;
	assign o_s_axi_wready = wready_r;
	assign o_s_axi_bvalid = bvalid_r;
	assign o_s_axi_bresp = bresp_r;
	assign o_s_axi_arready = arready_r;
	assign o_s_axi_rvalid = rvalid_r;
	assign o_s_axi_rdata = rdata_r;
	assign o_s_axi_rresp = rresp_r;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_fetch(logic [7:0] op);
		state_r == aai_pkg::ST_OP1 && i_ce && i_mem_data == op;
	endsequence
	sequence s_y_sum;
		s_fetch(aai_pkg::OPC_Y_PREFIX) ##1
		(state_r == aai_pkg::ST_OP2 && i_ce &&
		i_mem_data == aai_pkg::OPC_ADD_B_X);
	endsequence

	a_sum_cycles:
	assert property (s_fetch(aai_pkg::OPC_ACC_SUM) |=>
		state_r == aai_pkg::ST_SKIP &&
		addr_r == $past(addr_r) + 16'h0001)
		else $error("sum op second read not at next address");
	a_sum_result:
	assert property ((state_r == aai_pkg::ST_SKIP &&
		kind_r == aai_pkg::K_ACC_SUM && i_ce) |=>
		acc_a_r == 8'($past(acc_a_r) + $past(acc_b_r)) &&
		acc_b_r == $past(acc_b_r))
		else $error("sum op result wrong");
	a_dummy_addr:
	assert property (state_r == aai_pkg::ST_DUMMY |->
		addr_r == aai_pkg::DUMMY_ADDR && cycle_r)
		else $error("dummy cycle not at all-ones address");
	a_y_sum_seq:
	assert property (s_y_sum |=> state_r == aai_pkg::ST_SKIP &&
		addr_r == $past(addr_r) + 16'h0001)
		else $error("add-to-Y sequence wrong");
	a_x_index_add:
	assert property ((state_r == aai_pkg::ST_DUMMY &&
		kind_r == aai_pkg::K_ADD_BX && i_ce) |=>
		x_r == $past(x_r) + {8'h00, $past(acc_b_r)} &&
		flags_r == $past(flags_r))
		else $error("add-to-X result or flags wrong");
	a_y_index_add:
	assert property ((state_r == aai_pkg::ST_DUMMY &&
		kind_r == aai_pkg::K_ADD_BY && i_ce) |=>
		y_r == $past(y_r) + {8'h00, $past(acc_b_r)} &&
		flags_r == $past(flags_r))
		else $error("add-to-Y result or flags wrong");
	a_carry_add_a:
	assert property ((state_r == aai_pkg::ST_MEM && i_ce && !selb_r) |=>
		acc_a_r == 8'($past(acc_a_r) + $past(i_mem_data) +
		{7'h00, $past(flags_r[aai_pkg::FLG_CARRY])}))
		else $error("carry add to A wrong");
	a_zero_neg:
	assert property ((execute && arith && i_ce) |=>
		flags_r[aai_pkg::FLG_ZERO] == ($past(alu_bus.sum) == 8'h00) &&
		flags_r[aai_pkg::FLG_NEG] == $past(alu_bus.sum[7]))
		else $error("zero or negative flag wrong");
	a_page_zero:
	assert property ((state_r == aai_pkg::ST_OPND &&
		mode_r == aai_pkg::MODE_DIRECT && i_ce) |=>
		addr_r == {aai_pkg::PAGE_ZERO, $past(i_mem_data)})
		else $error("direct operand not in page zero");
	a_read_only:
	assert property ((i_ce && state_r != aai_pkg::ST_IDLE) |=>
		rw_r && flags_r[7:6] == $past(flags_r[7:6]) &&
		flags_r[aai_pkg::FLG_IMASK] == $past(flags_r[aai_pkg::FLG_IMASK]))
		else $error("write cycle or mask flag changed");
	a_next_fetch:
	assert property ((execute && i_ce && run_r) |=>
		state_r == aai_pkg::ST_OP1 && addr_r == pc_r)
		else $error("next fetch address wrong");

endmodule // aai_core

// ==== logic/aai_pkg.sv ====
// shared constants and types of the accumulator add execution block
package aai_pkg;

	// ---------------------------------------------------------------
	// register map (byte addresses, one word each)
	// ---------------------------------------------------------------
	localparam int unsigned AXI_AW = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_ACC_A = 8'h08;
	localparam logic [7:0] REG_ACC_B = 8'h0c;
	localparam logic [7:0] REG_X_INDEX = 8'h10;
	localparam logic [7:0] REG_Y_INDEX = 8'h14;
	localparam logic [7:0] REG_PC = 8'h18;
	localparam logic [7:0] REG_FLAGS = 8'h1c;
	localparam int CTRL_RUN = 0;
	localparam int STAT_HALTED = 0;
	localparam int STAT_ILLEGAL = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ---------------------------------------------------------------
	// condition flag layout and reset values
	// ---------------------------------------------------------------
	localparam int FLG_STOP = 7;
	localparam int FLG_XMASK = 6;
	localparam int FLG_HALF = 5;
	localparam int FLG_IMASK = 4;
	localparam int FLG_NEG = 3;
	localparam int FLG_ZERO = 2;
	localparam int FLG_OVF = 1;
	localparam int FLG_CARRY = 0;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [15:0] PC_RST = 16'h0000;

	// ---------------------------------------------------------------
	// opcodes and fixed addresses
	// ---------------------------------------------------------------
	localparam logic [7:0] OPC_ACC_SUM = 8'h1b;
	localparam logic [7:0] OPC_ADD_B_X = 8'h3a;
	localparam logic [7:0] OPC_Y_PREFIX = 8'h18;
	localparam logic [7:0] OPC_CARRY_A_IMMED = 8'h89;
	localparam logic [7:0] OPC_CARRY_A_DIRECT = 8'h99;
	localparam logic [7:0] OPC_CARRY_A_EXTENDED = 8'hb9;
	localparam logic [7:0] OPC_CARRY_A_INDEXED = 8'ha9;
	localparam logic [7:0] OPC_CARRY_B_IMMED = 8'hc9;
	localparam logic [7:0] OPC_CARRY_B_DIRECT = 8'hd9;
	localparam logic [7:0] OPC_CARRY_B_EXTENDED = 8'hf9;
	localparam logic [7:0] OPC_CARRY_B_INDEXED = 8'he9;
	localparam logic [15:0] DUMMY_ADDR = 16'hffff;
	localparam logic [7:0] PAGE_ZERO = 8'h00;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_OP1 = 3'b001,
		ST_OP2 = 3'b010,
		ST_SKIP = 3'b011,
		ST_OPND = 3'b100,
		ST_ADLO = 3'b101,
		ST_DUMMY = 3'b110,
		ST_MEM = 3'b111
	} aai_state_e;

	typedef enum logic [1:0] {
		K_ACC_SUM = 2'b00,
		K_ADD_BX = 2'b01,
		K_ADD_BY = 2'b10,
		K_CARRY = 2'b11
	} aai_kind_e;

	typedef enum logic [2:0] {
		MODE_IMMED = 3'b000,
		MODE_DIRECT = 3'b001,
		MODE_EXTENDED = 3'b010,
		MODE_XIDX = 3'b011,
		MODE_YIDX = 3'b100
	} aai_mode_e;

endpackage

// ==== testbench/aai_core_tb.sv ====
// self-checking bench for the add execution core
`timescale 1ns/1ps
module aai_core_tb;
	logic i_clk, i_rst, i_ce;
	logic [7:0] mem_data, awaddr, araddr;
	logic [15:0] mem_addr;
	logic mem_rw, mem_cycle, awvalid, awready, wvalid, wready;
	logic bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, q;
	logic [1:0] bresp, rresp, rs;
	logic [7:0] ea, eb, ef;
	logic [15:0] ex, ey, pc;
	logic [15:0] xq[$], gq[$];
	int error_cnt, tests_run, n;

	aai_core i_aai_core (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_mem_data(mem_data),
		.o_mem_addr(mem_addr),
		.o_mem_rw(mem_rw),
		.o_mem_cycle(mem_cycle),
		.i_s_axi_awaddr(awaddr),
		.i_s_axi_awvalid(awvalid),
		.o_s_axi_awready(awready),
		.i_s_axi_wdata(wdata),
		.i_s_axi_wstrb(4'hf),
		.i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready),
		.o_s_axi_bresp(bresp),
		.o_s_axi_bvalid(bvalid),
		.i_s_axi_bready(bready),
		.i_s_axi_araddr(araddr),
		.i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready),
		.o_s_axi_rdata(rdata),
		.o_s_axi_rresp(rresp),
		.o_s_axi_rvalid(rvalid),
		.i_s_axi_rready(rready)
	);

	aai_mem_model i_aai_mem_model (
		.i_clk(i_clk),
		.i_cycle(mem_cycle),
		.i_addr(mem_addr),
		.o_data(mem_data)
	);

	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	// ---------------------------------------------------------------
	// bus tasks and expected-value model
	// ---------------------------------------------------------------
	task report_and_stop();
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask

	// handshakes judged at the falling edge so they never race the slave
	task acc(input bit w, input logic [7:0] a, input logic [31:0] d);
		bit pa, pw, pr, ka, kw, kb;
		pa = 1;
		pw = w;
		pr = 1;
		@(posedge i_clk);
		if (w) begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
		end else begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
		end
		for (n = 0; n < 60 && pr; n++) begin
			@(negedge i_clk);
			ka = pa && (w ? awready : arready);
			kw = pw && wready;
			kb = w ? bvalid : rvalid;
			rs = w ? bresp : rresp;
			q = rdata;
			@(posedge i_clk);
			if (ka) begin
				pa = 0;
				awvalid <= 1'b0;
				arvalid <= 1'b0;
			end
			if (kw) begin
				pw = 0;
				wvalid <= 1'b0;
			end
			if (kb) begin
				pr = 0;
				bready <= 1'b0;
				rready <= 1'b0;
			end
		end
		if (pr) begin
			error_cnt++;
			$display("CHECK FAILED %0t bus timeout", $time);
			report_and_stop();
		end
	endtask

	task rc(input logic [7:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(q, e);
	endtask

	task put(input logic [7:0] b);
		i_aai_mem_model.mem[pc] = b;
		xq.push_back(pc);
		pc++;
	endtask

	task f8(input logic [7:0] a, input logic [7:0] m, input logic c,
		output logic [7:0] r);
		r = a + m + {7'h0, c};
		ef[5] = a[3] & m[3] | m[3] & ~r[3] | ~r[3] & a[3];
		ef[3] = r[7];
		ef[2] = (r == 8'h00);
		ef[1] = a[7] & m[7] & ~r[7] | ~a[7] & ~m[7] & r[7];
		ef[0] = a[7] & m[7] | m[7] & ~r[7] | ~r[7] & a[7];
	endtask

	// opcode bits 5:4 pick the mode, bit 6 the accumulator
	task adc(input logic [7:0] o, input bit y, input logic [7:0] v,
		input logic [7:0] lo);
		logic [15:0] t;
		logic [7:0] r;
		t = 16'h0;
		if (y) put(8'h18);
		put(o);
		case (o[5:4])
			2'h0: put(v);
			2'h1: begin
				put(lo);
				t = {8'h00, lo};
			end
			2'h2: begin
				put(lo);
				t = (y ? ey : ex) + {8'h00, lo};
				xq.push_back(16'hffff);
			end
			default: begin
				put(8'h20);
				put(lo);
				t = {8'h20, lo};
			end
		endcase
		if (o[5:4] != 2'h0) begin
			xq.push_back(t);
			i_aai_mem_model.mem[t] = v;
		end
		f8(o[6] ? eb : ea, v, ef[0], r);
		if (o[6]) eb = r;
		else ea = r;
	endtask

	always @(posedge i_clk) begin
		// a frozen cycle is still one bus cycle, logged once
		if (mem_cycle === 1'b1 && i_ce === 1'b1) begin
			gq.push_back(mem_addr);
			chk({31'h0, mem_rw}, 32'h1);
		end
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		i_rst = 1'b1;
		i_ce = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata} = 48'h0;
		error_cnt = 0;
		tests_run = 0;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		rc(aai_pkg::REG_PC, 32'h0);
		rc(aai_pkg::REG_FLAGS, 32'h0);
		rc(aai_pkg::REG_STATUS, 32'h1);
		rc(8'h20, 32'h0);
		chk({30'h0, rs}, {30'h0, aai_pkg::RESP_SLVERR});
		acc(1'b1, 8'h24, 32'h1);
		chk({30'h0, rs}, {30'h0, aai_pkg::RESP_SLVERR});
		ea = 8'h88;
		eb = 8'h88;
		ex = 16'h12ff;
		ey = 16'h30f0;
		ef = 8'hd0;
		pc = 16'h0100;
		acc(1'b1, aai_pkg::REG_ACC_A, {24'h0, ea});
		acc(1'b1, aai_pkg::REG_ACC_B, {24'h0, eb});
		acc(1'b1, aai_pkg::REG_X_INDEX, {16'h0, ex});
		acc(1'b1, aai_pkg::REG_Y_INDEX, {16'h0, ey});
		acc(1'b1, aai_pkg::REG_PC, {16'h0, pc});
		acc(1'b1, aai_pkg::REG_FLAGS, {24'h0, ef});
		// carries at bit 3 and bit 7 at once, stop and masks preset
		put(8'h1b);
		xq.push_back(pc);
		f8(ea, eb, 1'b0, ea);
		put(8'h3a);
		xq.push_back(pc);
		xq.push_back(16'hffff);
		ex = ex + {8'h00, eb};
		put(8'h18);
		put(8'h3a);
		xq.push_back(pc);
		xq.push_back(16'hffff);
		ey = ey + {8'h00, eb};
		adc(8'h89, 1'b0, 8'h70, 8'h00);
		adc(8'hc9, 1'b0, 8'h0f, 8'h00);
		adc(8'h99, 1'b0, 8'h80, 8'h40);
		adc(8'hd9, 1'b0, 8'h7f, 8'h41);
		adc(8'hb9, 1'b0, 8'h3c, 8'h50);
		adc(8'hf9, 1'b0, 8'hc4, 8'h51);
		adc(8'ha9, 1'b0, 8'h9a, 8'h10);
		adc(8'he9, 1'b0, 8'h66, 8'h20);
		adc(8'ha9, 1'b1, 8'h55, 8'h05);
		adc(8'he9, 1'b1, 8'h00 - eb - {7'h0, ef[0]}, 8'h06);
		xq.push_back(pc);
		acc(1'b1, aai_pkg::REG_CTRL, 32'h1);
		// freeze the core over its first fetch; no bus traffic meanwhile
		i_ce <= 1'b0;
		repeat (5) @(posedge i_clk);
		i_ce <= 1'b1;
		for (int k = 0; k < 100; k++) begin
			acc(1'b0, aai_pkg::REG_STATUS, 32'h0);
			if (q[1] === 1'b1) break;
		end
		chk(q, 32'h3);
		rc(aai_pkg::REG_ACC_A, {24'h0, ea});
		rc(aai_pkg::REG_ACC_B, {24'h0, eb});
		rc(aai_pkg::REG_X_INDEX, {16'h0, ex});
		rc(aai_pkg::REG_Y_INDEX, {16'h0, ey});
		rc(aai_pkg::REG_FLAGS, {24'h0, ef});
		rc(aai_pkg::REG_PC, {16'h0, pc});
		foreach (xq[i]) begin
			chk({16'h0, gq[i]}, {16'h0, xq[i]});
		end
		chk(gq.size(), xq.size());
		rc(aai_pkg::REG_CTRL, 32'h0);
		acc(1'b1, aai_pkg::REG_STATUS, 32'h2);
		rc(aai_pkg::REG_STATUS, 32'h1);
		report_and_stop();
	end
endmodule // aai_core_tb

// ==== testbench/aai_mem_model.sv ====
// memory model answering opcode and operand reads
`timescale 1ns/1ps
module aai_mem_model (
	input wire logic i_clk,
	input wire logic i_cycle,
	input wire logic [15:0] i_addr,
	output logic [7:0] o_data
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_r;

	// idle bus shows the inverse of the last byte, never a stale copy
	assign o_data = i_cycle ? mem[i_addr] : ~last_r;

	initial begin
		last_r = 8'h00;
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'h00;
		end
	end

	always @(posedge i_clk) begin
		if (i_cycle) begin
			last_r <= o_data;
		end
	end
endmodule // aai_mem_model
